// file: asc_ctrl.sv
// host controller driving an asynchronous 128k x 8 static memory
// Function
// - store only while both selects and strobe active
// - store window opens at last qualifying edge
// - store window closes at first releasing edge
// - store window open at least 55 ns
// - selects held 60 ns before store end
// - location stable 60 ns before store end
// - location valid before window opens
// - write data driven 30 ns before close
// - write data held through window close
// - never drive bus while device may drive
// - stay deselected 5 ms after retention exit
`timescale 1ns/100ps
`default_nettype none
`include "asc_regs.svh"

module asc_ctrl
  import asc_pkg::*;
#(
  parameter int ADDR_W = `ASC_ADDR_W,
  parameter int DATA_W = `ASC_DATA_W,
  parameter int CNT_W = 16,
  parameter int ACCESS_CYC = `ASC_ACCESS_CYC,
  parameter int STORE_CYC = `ASC_STORE_CYC,
  parameter int TURN_CYC = `ASC_TURN_CYC,
  parameter int RETENTION_WAIT_CYC = `ASC_RETENTION_EXIT_CYC
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic retention_req,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata,
  output logic chip_select_low_active_n,
  output logic chip_select_high_active,
  output logic write_strobe_n,
  output logic output_gate_n,
  output logic [ADDR_W-1:0] word_select_lines,
  output logic [DATA_W-1:0] byte_lane_pins_o,
  output logic byte_lane_pins_oe,
  input wire logic [DATA_W-1:0] byte_lane_pins_i
);

  asc_state_t state;
  asc_state_t next_state;
  logic take;
  logic timer_load;
  logic [CNT_W-1:0] timer_value;
  logic timer_expired;
  logic read_done;

  function automatic logic [CNT_W-1:0] phase_load(input int cycles);
    phase_load = CNT_W'(cycles - 1);
  endfunction

  asc_wait_timer #(
    .CNT_W(CNT_W)
  ) u_timer (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .load(timer_load),
    .load_value(timer_value),
    .expired(timer_expired)
  );

  // retention request outranks a pending access
  assign req_ready = (state == ST_IDLE) && !retention_req;
  assign take = req_valid && req_ready;
  assign read_done = (state == ST_RD_ACCESS) && timer_expired;

  always_comb
  begin
    next_state = state;
    timer_load = 1'b0;
    timer_value = '0;
    case (state)
      ST_RETAIN:
      begin
        if (!retention_req)
        begin
          next_state = ST_WAKE;
          timer_load = 1'b1;
          timer_value = phase_load(RETENTION_WAIT_CYC);
        end
      end
      ST_WAKE:
        if (retention_req)
          next_state = ST_RETAIN;
        else if (timer_expired)
          next_state = ST_IDLE;
      ST_IDLE:
      begin
        if (retention_req)
          next_state = ST_RETAIN;
        else if (take && req_write)
          next_state = ST_WR_SETUP;
        else if (take)
        begin
          next_state = ST_RD_ACCESS;
          timer_load = 1'b1;
          timer_value = phase_load(ACCESS_CYC);
        end
      end
      ST_RD_ACCESS:
      begin
        if (timer_expired)
        begin
          next_state = ST_TURN;
          timer_load = 1'b1;
          timer_value = phase_load(TURN_CYC);
        end
      end
      ST_TURN:
        if (timer_expired)
          next_state = ST_IDLE;
      ST_WR_SETUP:
      begin
        next_state = ST_WR_PULSE;
        timer_load = 1'b1;
        timer_value = phase_load(STORE_CYC);
      end
      ST_WR_PULSE:
        if (timer_expired)
          next_state = ST_WR_END;
      ST_WR_END:
        next_state = ST_IDLE;
      default:
        next_state = ST_RETAIN;
    endcase
  end

  // power-up is treated like leaving retention: the exit wait applies
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      state <= ST_RETAIN;
    else
      state <= next_state;
  end

  // pins are registered from the next state so strobes never glitch
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      chip_select_low_active_n <= 1'b1;
      chip_select_high_active <= 1'b0;
      write_strobe_n <= 1'b1;
      output_gate_n <= 1'b1;
      byte_lane_pins_oe <= 1'b0;
    end
    else
    begin
      case (next_state)
        ST_RD_ACCESS:
        begin
          chip_select_low_active_n <= 1'b0;
          chip_select_high_active <= 1'b1;
          write_strobe_n <= 1'b1;
          output_gate_n <= 1'b0;
          byte_lane_pins_oe <= 1'b0;
        end
        ST_TURN, ST_WR_SETUP, ST_WR_END:
        begin
          // selects lead and trail the strobe so it alone opens and closes
          chip_select_low_active_n <= 1'b0;
          chip_select_high_active <= 1'b1;
          write_strobe_n <= 1'b1;
          output_gate_n <= 1'b1;
          // bus stays free in turnaround while the memory lets go
          byte_lane_pins_oe <= (next_state != ST_TURN);
        end
        ST_WR_PULSE:
        begin
          chip_select_low_active_n <= 1'b0;
          chip_select_high_active <= 1'b1;
          write_strobe_n <= 1'b0;
          output_gate_n <= 1'b1;
          byte_lane_pins_oe <= 1'b1;
        end
        default:
        begin
          chip_select_low_active_n <= 1'b1;
          chip_select_high_active <= 1'b0;
          write_strobe_n <= 1'b1;
          output_gate_n <= 1'b1;
          byte_lane_pins_oe <= 1'b0;
        end
      endcase
    end
  end

  // location and data change only when a request is taken
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      word_select_lines <= '0;
      byte_lane_pins_o <= '0;
    end
    else if (take)
    begin
      word_select_lines <= req_addr;
      byte_lane_pins_o <= req_wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end
    else
    begin
      rsp_valid <= read_done || (state == ST_WR_END);
      if (read_done)
        rsp_rdata <= byte_lane_pins_i;
    end
  end

  // helper counters read only by the checks below
  logic [7:0] low_cnt;
  logic [CNT_W:0] wake_cnt;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      low_cnt <= '0;
    else if (write_strobe_n)
      low_cnt <= '0;
    else if (low_cnt != 8'hFF)
      low_cnt <= low_cnt + 8'h01;
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      wake_cnt <= '0;
    else if (state != ST_WAKE)
      wake_cnt <= '0;
    else
      wake_cnt <= wake_cnt + (CNT_W + 1)'(1);
  end

  sequence s_selected;
    !chip_select_low_active_n && chip_select_high_active;
  endsequence
  sequence s_location_held;
    $stable(word_select_lines) ##1 $stable(word_select_lines)
      ##1 $stable(word_select_lines);
  endsequence
  property p_store_qualified;
    @(posedge ref_clk) disable iff (!reset_n)
      !write_strobe_n |-> s_selected;
  endproperty
  a_store_qualified: assert property (p_store_qualified)
    else $error("strobe low while a select is inactive");
  property p_opens_on_strobe;
    @(posedge ref_clk) disable iff (!reset_n)
      $fell(write_strobe_n) |->
        $past(!chip_select_low_active_n && chip_select_high_active);
  endproperty
  a_opens_on_strobe: assert property (p_opens_on_strobe)
    else $error("selects were not active before strobe fell");
  property p_closes_on_strobe;
    @(posedge ref_clk) disable iff (!reset_n)
      $rose(write_strobe_n) |-> s_selected;
  endproperty
  a_closes_on_strobe: assert property (p_closes_on_strobe)
    else $error("selects released before strobe rose");
  // low_cnt seen at the rising edge already counts every low clock
  property p_store_window;
    @(posedge ref_clk) disable iff (!reset_n)
      $rose(write_strobe_n) |-> (low_cnt >= 8'(STORE_CYC));
  endproperty
  a_store_window: assert property (p_store_window)
    else $error("store window shorter than its minimum");
  property p_select_lead;
    @(posedge ref_clk) disable iff (!reset_n)
      $rose(write_strobe_n) |->
        $past(!chip_select_low_active_n && chip_select_high_active, 2);
  endproperty
  a_select_lead: assert property (p_select_lead)
    else $error("selects not held long enough before store end");
  property p_location_stable;
    @(posedge ref_clk) disable iff (!reset_n)
      $fell(write_strobe_n) |-> s_location_held;
  endproperty
  a_location_stable: assert property (p_location_stable)
    else $error("location changed around the store window");
  property p_data_lead;
    @(posedge ref_clk) disable iff (!reset_n)
      $fell(write_strobe_n) |-> byte_lane_pins_oe && $past(byte_lane_pins_oe);
  endproperty
  a_data_lead: assert property (p_data_lead)
    else $error("write data not driven before window opened");
  property p_data_hold;
    @(posedge ref_clk) disable iff (!reset_n)
      $rose(write_strobe_n) |->
        byte_lane_pins_oe && $stable(byte_lane_pins_o);
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("write data released before window closed");
  property p_no_contention;
    @(posedge ref_clk) disable iff (!reset_n)
      byte_lane_pins_oe |-> output_gate_n && $past(output_gate_n);
  endproperty
  a_no_contention: assert property (p_no_contention)
    else $error("bus driven while memory may still drive it");
  property p_exit_wait;
    @(posedge ref_clk) disable iff (!reset_n)
      (state == ST_IDLE && $past(state) == ST_WAKE) |->
        (wake_cnt == (CNT_W + 1)'(RETENTION_WAIT_CYC));
  endproperty
  a_exit_wait: assert property (p_exit_wait)
    else $error("access allowed before retention exit wait ended");

endmodule // asc_ctrl

`default_nettype wire

// file: asc_pkg.sv
// types shared by the asynchronous sram controller
`default_nettype none
package asc_pkg;

  typedef enum logic [3:0] {
    ST_RETAIN,
    ST_WAKE,
    ST_IDLE,
    ST_RD_ACCESS,
    ST_TURN,
    ST_WR_SETUP,
    ST_WR_PULSE,
    ST_WR_END
  } asc_state_t;

endpackage

`default_nettype wire

// file: asc_regs.svh
// timing counts, widths and sizes for the asynchronous sram controller
`ifndef ASC_REGS_SVH
`define ASC_REGS_SVH

`define ASC_ADDR_W 17
`define ASC_DATA_W 8
`define ASC_DEPTH 131072

`define ASC_CLK_PERIOD_NS 100

`define ASC_ACCESS_NS 70
`define ASC_GATE_TO_VALID_NS 40
`define ASC_GATE_TO_FLOAT_NS 30
`define ASC_STORE_WINDOW_MIN_NS 55
`define ASC_SELECT_TO_STORE_END_NS 60
`define ASC_LOCATION_VALID_TO_STORE_END_NS 60
`define ASC_INPUT_LEAD_TIME_NS 30
`define ASC_RETENTION_EXIT_WAIT_MS 5

// least times, rounded up to whole clocks
`define ASC_ACCESS_CYC \
  ((`ASC_ACCESS_NS + `ASC_CLK_PERIOD_NS - 1) / `ASC_CLK_PERIOD_NS)
`define ASC_STORE_CYC \
  ((`ASC_STORE_WINDOW_MIN_NS + `ASC_CLK_PERIOD_NS - 1) / `ASC_CLK_PERIOD_NS)
`define ASC_TURN_CYC \
  ((`ASC_GATE_TO_FLOAT_NS + `ASC_CLK_PERIOD_NS - 1) / `ASC_CLK_PERIOD_NS)
`define ASC_RETENTION_EXIT_CYC \
  ((`ASC_RETENTION_EXIT_WAIT_MS * 1000000 + `ASC_CLK_PERIOD_NS - 1) \
   / `ASC_CLK_PERIOD_NS)

`endif

// file: asc_sram_model.sv
// behavioural model of the 128k x 8 static memory on the far side
`timescale 1ns/100ps
`default_nettype none

module asc_sram_model (
  input wire logic sel_n,
  input wire logic sel,
  input wire logic we_n,
  input wire logic gate_n,
  input wire logic [16:0] addr,
  input wire logic [7:0] host_data,
  input wire logic host_oe,
  input wire logic slow,
  output logic [7:0] bus,
  output int faults
);
  logic [7:0] mem [0:131071];
  wire [7:0] rd;
  wire on;
  wire want;
  wire want_f;
  wire want_s;
  wire drive;
  wire wopen;
  realtime t_open;
  realtime t_sel;
  realtime t_addr;
  realtime t_data;

  assign on = !sel_n && sel;
  assign want = on && we_n && !gate_n;
  assign #5 want_f = want;
  assign #65 want_s = want;
  // release is immediate, only turn-on is delayed
  assign drive = want && (slow ? want_s : want_f);
  assign wopen = on && !we_n;
  // undriven bus shows the inverse so a stale byte never passes
  assign bus = host_oe ? host_data : drive ? rd : ~rd;

  initial
    for (int i = 0; i < 131072; i++)
      mem[i] = 8'hA5;
  // old byte lingers a while after the location moves
  assign #10 rd = mem[addr];
  always @(posedge on) t_sel = $realtime;
  always @(host_data) t_data = $realtime;
  always @(posedge wopen) t_open = $realtime;

  always @(addr)
  begin
    if (wopen === 1'b1)
      faults += 1;
    t_addr = $realtime;
  end

  // no window opened yet: only the settle out of unknown
  always @(negedge wopen)
    if (t_open > 0)
    begin
      if ($realtime - t_open < 55)
        faults += 1;
      if ($realtime - t_sel < 60)
        faults += 1;
      if ($realtime - t_addr < 60)
        faults += 1;
      if ($realtime - t_data < 30 || host_oe !== 1'b1)
        faults += 1;
      mem[addr] = host_data;
    end

  always @(host_oe, drive)
    if (host_oe === 1'b1 && drive === 1'b1)
      faults += 1;
endmodule // asc_sram_model

`default_nettype wire

// file: asc_wait_timer.sv
// loadable down counter that times the wake, read access, turnaround and store phases of the controller
`timescale 1ns/100ps
`default_nettype none

module asc_wait_timer #(
  parameter int CNT_W = 16
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic load,
  input wire logic [CNT_W-1:0] load_value,
  output logic expired
);

  logic [CNT_W-1:0] count;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      count <= '0;
    else if (load)
      count <= load_value;
    else if (count != '0)
      count <= count - CNT_W'(1);
  end

  assign expired = (count == '0);

  property p_timer_load;
    @(posedge ref_clk) disable iff (!reset_n)
      load |=> (count == $past(load_value));
  endproperty
  a_timer_load: assert property (p_timer_load)
    else $error("timer did not take its load value");

  property p_timer_step;
    @(posedge ref_clk) disable iff (!reset_n)
      (!load && count != '0) |=> (count == $past(count) - CNT_W'(1));
  endproperty
  a_timer_step: assert property (p_timer_step)
    else $error("timer did not count down by one");

endmodule // asc_wait_timer

`default_nettype wire

// file: async_sram_128k_x8_bench.sv
// self-checking bench for the asynchronous sram controller
`timescale 1ns/100ps
`default_nettype none

module async_sram_128k_x8_bench;
  localparam int W = 8;
  logic ref_clk = 1'b0;
  logic reset_n, retention_req, req_valid, req_write, slow;
  logic req_ready, rsp_valid, sel_n, sel, we_n, gate_n, oe;
  logic [16:0] req_addr, addr;
  logic [7:0] req_wdata, rsp_rdata, data_o, data_i;
  logic [8:0] expq [$];
  logic [7:0] ref_mem [int];
  logic [16:0] addrs [$];
  logic [31:0] seed = 32'h39EA;
  int err_count, total_checks, faults;

  always #50 ref_clk = ~ref_clk;

  asc_ctrl #(.RETENTION_WAIT_CYC(W)) DUT (
    .ref_clk(ref_clk), .reset_n(reset_n), .retention_req(retention_req),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .chip_select_low_active_n(sel_n),
    .chip_select_high_active(sel), .write_strobe_n(we_n),
    .output_gate_n(gate_n), .word_select_lines(addr),
    .byte_lane_pins_o(data_o), .byte_lane_pins_oe(oe),
    .byte_lane_pins_i(data_i)
  );

  asc_sram_model far_end (
    .sel_n(sel_n), .sel(sel), .we_n(we_n), .gate_n(gate_n),
    .addr(addr), .host_data(data_o), .host_oe(oe), .slow(slow),
    .bus(data_i), .faults(faults)
  );

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic bad(input string m);
    err_count++;
    $display("unexpected %0t: %s", $time, m);
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // memory must stay deselected: checks the retain clock before the wake and the first W-1 of the W scaled wake clocks
  task automatic wake_check();
    for (int n = 0; n < W; n++)
    begin
      @(negedge ref_clk);
      total_checks++;
      if (req_ready !== 1'b0 || sel_n !== 1'b1)
        bad("access before wake wait");
    end
    @(posedge ref_clk);
  endtask

  // request stays up, so the next one waits in the refused state
  task automatic do_req(input logic wr, input logic [16:0] a,
                        input logic [7:0] d);
    int n;
    n = 0;
    req_valid <= 1'b1;
    req_write <= wr;
    req_addr <= a;
    req_wdata <= d;
    expq.push_back({wr, wr ? 8'h00 : ref_mem[a]});
    if (wr)
      ref_mem[a] = d;
    do
    begin
      @(negedge ref_clk);
      n++;
    end
    while (req_ready !== 1'b1 && n < 200);
    if (n >= 200)
      bad("request never taken");
    @(posedge ref_clk);
  endtask

  always @(negedge ref_clk)
    if (rsp_valid === 1'b1)
    begin
      total_checks++;
      if (expq.size() == 0)
        bad("response without request");
      else if (!expq[0][8] && rsp_rdata !== expq[0][7:0])
        bad("read data mismatch");
      if (expq.size() != 0)
        void'(expq.pop_front());
    end

  initial
  begin
    #(4000 * 100);
    bad("watchdog expired");
    finish_test();
  end

  initial
  begin
    logic [16:0] a;
    reset_n = 1'b0;
    retention_req = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 17'h00000;
    req_wdata = 8'h00;
    slow = 1'b0;
    repeat (20) @(posedge ref_clk);
    total_checks++;
    if (sel_n !== 1'b1 || sel !== 1'b0 || oe !== 1'b0)
      bad("pins active in reset");
    reset_n <= 1'b1;
    wake_check();
    for (int i = 0; i < 48; i++)
    begin
      seed = xs(seed);
      slow <= seed[9];
      if (i < 2 || seed[8] || addrs.size() == 0)
      begin
        a = i == 0 ? 17'h00000 : i == 1 ? 17'h1FFFF : seed[16:0];
        addrs.push_back(a);
        do_req(1'b1, a, seed[31:24]);
      end
      else
        do_req(1'b0, addrs[seed[31:20] % addrs.size()], 8'h00);
    end
    // retention raised mid-access with a read still pending
    retention_req <= 1'b1;
    fork
      do_req(1'b0, 17'h1FFFF, 8'h00);
      begin
        repeat (6) @(posedge ref_clk);
        retention_req <= 1'b0;
        wake_check();
      end
    join
    req_valid <= 1'b0;
    repeat (8) @(posedge ref_clk);
    total_checks++;
    if (faults !== 0 || expq.size() != 0)
      bad("pin timing fault or lost response");
    finish_test();
  end
endmodule // async_sram_128k_x8_bench

`default_nettype wire
